// File: i2c_slave_cmd_translator_tb_top.sv
// Purpose: Self-checking bench for the two-wire command translator slave
// Assumes: Master model drives the bus; bench acts as the command stream target
// Notes:   Read data is a fixed function of the address, so prefetches are harmless
`timescale 1ns/1ps
module i2c_slave_cmd_translator_tb_top
   import i2ct_pkg::*;
;
   logic        mclk = 1'b0;
   logic        link_clk = 1'b0;
   logic        reset;
   logic [1:0]  pins;
   logic        sa_write;
   logic [6:0]  sa_data;
   logic        mss;
   logic        busy;
   logic [7:0]  rdata;
   logic        sda_o;
   logic        sda_oe;
   logic [15:0] addr;
   logic [7:0]  wdata;
   logic        space;
   logic        wr_strobe;
   logic        rd_strobe;
   logic        wen;
   logic [6:0]  slave_addr;
   logic        m_scl_low;
   logic        m_sda_low;
   wire         scl = ~m_scl_low;
   wire         sda = ~(m_sda_low | (sda_oe & ~sda_o));
   logic [24:0] wr_q [$];
   int          wen_n = 0;
   int          err_count = 0;
   int          checked = 0;

   i2ct_slave dut (.i_mclk(mclk), .i_reset(reset), .i_link_clk(link_clk), .i_scl(scl),
      .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_addr_pins(pins),
      .i_sa_write(sa_write), .i_sa_data(sa_data), .i_memory_space_select(mss),
      .i_ee_busy(busy), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_space(space),
      .o_wr_strobe(wr_strobe), .o_rd_strobe(rd_strobe), .o_write_enable(wen),
      .o_slave_address(slave_addr));

   i2ct_master_model m (.i_mclk(mclk), .i_sda(sda), .o_scl_low(m_scl_low),
      .o_sda_low(m_sda_low));

   always #5 mclk = ~mclk;

   // Link clock unrelated in phase to the core clock
   initial begin
      #37;
      forever #80 link_clk = ~link_clk;
   end

   function automatic logic [7:0] mem_val(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction

   always @(posedge mclk) begin
      if (rd_strobe === 1'b1) begin
         rdata <= #1 mem_val(addr);
      end
      if (wr_strobe === 1'b1) begin
         wr_q.push_back({space, addr, wdata});
      end
      if (wen === 1'b1) begin
         wen_n++;
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic send(input logic [6:0] a, input logic [7:0] d [$], input logic exp);
      logic ack;
      m.start();
      m.wr_byte({a, 1'b0}, ack);
      chk("address ack", exp, ack);
      foreach (d[i]) begin
         m.wr_byte(d[i], ack);
         chk("byte ack", exp, ack);
      end
   endtask

   task automatic recv(input logic [6:0] a, input logic [7:0] e [$]);
      logic       ack;
      logic [7:0] d;
      m.start();
      m.wr_byte({a, 1'b1}, ack);
      chk("read address ack", 1'b0, ack);
      foreach (e[i]) begin
         m.rd_byte(i == e.size() - 1, d);
         chk("read byte", e[i], d);
      end
      m.stop();
   endtask

   task automatic print_verdict();
      if (err_count == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      reset = 1'b1;
      pins = 2'h1;
      sa_write = 1'b0;
      sa_data = 7'h00;
      mss = 1'b0;
      busy = 1'b0;
      rdata = 8'h00;
      repeat (12) @(posedge mclk);
      #1;
      reset = 1'b0;
      repeat (20) @(posedge mclk);
      #1;
      chk("strap address", {5'h1D, 2'h1}, slave_addr);
      mss = 1'b1;
      send(7'h75, '{8'h02, 8'h12, 8'h34, 8'hAB, 8'hCD}, 1'b0);
      m.stop();
      chk("write count", 2, wr_q.size());
      chk("first write", {1'b1, 16'h1234, 8'hAB}, wr_q[0]);
      chk("second write", {1'b1, 16'h1235, 8'hCD}, wr_q[1]);
      mss = 1'b0;
      // Repeated start instead of stop keeps the read next on the bus
      send(7'h75, '{8'h03, 8'h00, 8'hFE}, 1'b0);
      recv(7'h75, '{mem_val(16'h00FE), mem_val(16'h00FF), mem_val(16'h0100)});
      for (int k = 0; k < 2; k++) begin
         busy = (k == 0);
         send(7'h75, '{8'h05}, 1'b0);
         m.stop();
         recv(7'h75, '{(k == 0) ? 8'h01 : 8'h00});
      end
      sa_data = 7'h2A;
      sa_write = 1'b1;
      @(posedge mclk);
      #1;
      sa_write = 1'b0;
      @(posedge mclk);
      #1;
      chk("new address", 7'h2A, slave_addr);
      // Old address and the general call address are both ignored
      send(7'h75, '{8'h06}, 1'b1);
      m.stop();
      send(7'h00, '{8'h06}, 1'b1);
      m.stop();
      chk("ignored enable", 0, wen_n);
      send(7'h2A, '{8'h06}, 1'b0);
      m.stop();
      chk("write enable", 1, wen_n);
      print_verdict();
   end

   // Watchdog against a hung bus
   initial begin
      repeat (90000) @(posedge mclk);
      err_count++;
      print_verdict();
   end
endmodule

// File: i2ct_master_model.sv
// Purpose: Two-wire bus master model that drives SCL and pulls SDA low
// Assumes: Both lines have pull-ups; the resolved SDA level comes back on i_sda
// Notes:   One bit takes four quarters of QTR core clocks, just under fast mode
`timescale 1ns/1ps
module i2ct_master_model #(
   parameter int QTR = 63
) (
   input  wire logic i_mclk,
   input  wire logic i_sda,
   output logic      o_scl_low,
   output logic      o_sda_low
);
   initial begin
      o_scl_low = 1'b0;
      o_sda_low = 1'b0;
   end

   task automatic qtr();
      repeat (QTR) @(posedge i_mclk);
      #1;
   endtask

   task automatic start();
      o_sda_low = 1'b0;
      qtr();
      o_scl_low = 1'b0;
      qtr();
      o_sda_low = 1'b1;
      qtr();
      o_scl_low = 1'b1;
      qtr();
   endtask

   task automatic bit_io(input logic b, output logic r);
      o_sda_low = ~b;
      qtr();
      o_scl_low = 1'b0;
      qtr();
      r = i_sda;
      qtr();
      o_scl_low = 1'b1;
      qtr();
   endtask

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, ack);
   endtask

   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask

   task automatic stop();
      o_sda_low = 1'b1;
      qtr();
      o_scl_low = 1'b0;
      qtr();
      o_sda_low = 1'b0;
      qtr();
   endtask
endmodule

// File: i2ct_params.svh
// Purpose: Constants for the two-wire command translator slave
// Assumes: Included by the slave module
// Notes:   Command codes match the internal command stream
`ifndef I2CT_PARAMS_SVH
`define I2CT_PARAMS_SVH
`define I2CT_CMD_WREN    8'h06
`define I2CT_CMD_WRITE   8'h02
`define I2CT_CMD_READ    8'h03
`define I2CT_CMD_STATUS  8'h05
`define I2CT_ADDR_UPPER  5'h1D
`define I2CT_ADDR_RESET  7'h74
`define I2CT_BITS        4'h8
`define I2CT_STRAP_WAIT  2'h2
`define I2CT_STRAP_DONE  2'h3
`define I2CT_IDX_DATA    2'h3
`endif

// File: i2ct_pkg.sv
// Purpose: Types for the two-wire command translator slave
// Assumes: Constants come from i2ct_params.svh
// Notes:   Link states follow a Gray path
package i2ct_pkg;
   typedef enum logic [2:0] {
      I2CT_IDLE     = 3'h0,
      I2CT_ADDR     = 3'h1,
      I2CT_ADDR_ACK = 3'h3,
      I2CT_RX       = 3'h2,
      I2CT_RX_ACK   = 3'h6,
      I2CT_TX       = 3'h7,
      I2CT_TX_ACK   = 3'h5
   } i2ct_state_t;
   typedef enum logic [1:0] {
      I2CT_K_READ   = 2'h0,
      I2CT_K_WRITE  = 2'h1,
      I2CT_K_WREN   = 2'h2,
      I2CT_K_STATUS = 2'h3
   } i2ct_kind_t;
endpackage

// File: i2ct_slave.sv
// Purpose: Two-wire slave port that turns bus transfers into a command stream
// Assumes: i_link_clk oversamples SCL/SDA several times per bit
// Notes:   Only i_reset clears this port; core reset bits never reach it
//
// Behaviour
// - Slave only, fast mode, master drives SCL
// - First written byte is the command code
// - Fetch during acknowledge, then bump read address
// - Fetched byte shifted out over eight clocks
// - Write: command, two address bytes, then data
// - Store each data byte, then bump address
// - Space select picks registers or EEPROM
// - Status byte LSB shows EEPROM busy
// - No high-speed, 10-bit, general call or ID
// - Never holds SCL low
// - Default address 11101 plus two strap pins
// - Address register writable by configuration script
// - All bytes sent most significant bit first
// - Repeated START accepted in place of STOP/START
// - Core reset bits leave this port untouched
`timescale 1ns/1ps
`include "i2ct_params.svh"
module i2ct_slave
   import i2ct_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_reset,
   input  wire logic        i_link_clk,
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   output logic             o_sda_o,
   output logic             o_sda_oe,
   input  wire logic [1:0]  i_addr_pins,
   input  wire logic        i_sa_write,
   input  wire logic [6:0]  i_sa_data,
   input  wire logic        i_memory_space_select,
   input  wire logic        i_ee_busy,
   input  wire logic [7:0]  i_rdata,
   output logic [15:0]      o_addr,
   output logic [7:0]       o_wdata,
   output logic             o_space,
   output logic             o_wr_strobe,
   output logic             o_rd_strobe,
   output logic             o_write_enable,
   output logic [6:0]       o_slave_address
);
   // Link domain: synchronisers and edge detect
   logic        scl1, scl2, scl_d, sda1, sda2, sda_d, rw, mack, req_tog;
   i2ct_state_t state;
   logic [3:0]  cnt;
   logic [7:0]  shreg, txreg, cmd, fetched, req_data;
   logic [15:0] link_addr, req_addr;
   logic [1:0]  byte_idx;
   i2ct_kind_t  req_kind;
   logic [6:0]  link_sa;
   logic        rs1, rs2, rs3, st1, st2, st3;
   // Core domain
   logic        rq1, rq2, rq3, rd_pend, st_pend, rsp_tog, sa_tog;
   logic [7:0]  rsp_data;
   logic [1:0]  pin1, pin2, strap_cnt;
   wire scl_rise  = scl2 & ~scl_d;
   wire scl_fall  = ~scl2 & scl_d;
   wire start_c   = scl2 & scl_d & sda_d & ~sda2;
   wire stop_c    = scl2 & scl_d & ~sda_d & sda2;
   wire byte_done = scl_fall & (cnt == `I2CT_BITS);
   wire addr_hit  = (shreg[7:1] == link_sa);
   wire rsp_edge  = rs2 ^ rs3;
   wire sa_edge   = st2 ^ st3;
   wire is_status = (cmd == `I2CT_CMD_STATUS);
   wire req_edge  = rq2 ^ rq3;
   // Crossed words are stable while their toggle is in flight
   always_ff @(posedge i_link_clk or posedge i_reset) begin
      if (i_reset) begin
         {scl1, scl2, scl_d, sda1, sda2, sda_d} <= 6'h3F;
         {rs1, rs2, rs3, st1, st2, st3} <= 6'h00;
         fetched <= 8'h00;
         link_sa <= `I2CT_ADDR_RESET;
         o_sda_o <= 1'b0;
      end else begin
         {scl1, scl2, scl_d} <= {i_scl, scl1, scl2};
         {sda1, sda2, sda_d} <= {i_sda, sda1, sda2};
         {rs1, rs2, rs3} <= {rsp_tog, rs1, rs2};
         {st1, st2, st3} <= {sa_tog, st1, st2};
         if (rsp_edge)
            fetched <= rsp_data;
         if (sa_edge)
            link_sa <= o_slave_address;
         // Pure slave; the SDA driver is open drain only
         o_sda_o <= 1'b0;
      end
   end
   // Link state machine; SCL is only ever sampled, never driven
   always_ff @(posedge i_link_clk or posedge i_reset) begin
      if (i_reset) begin
         state <= I2CT_IDLE;
         cnt <= 4'h0;
         shreg <= 8'h00;
         txreg <= 8'h00;
         cmd <= 8'h00;
         link_addr <= 16'h0000;
         byte_idx <= 2'h0;
         rw <= 1'b0;
         mack <= 1'b0;
         o_sda_oe <= 1'b0;
         req_tog <= 1'b0;
         req_kind <= I2CT_K_READ;
         req_addr <= 16'h0000;
         req_data <= 8'h00;
      end else if (start_c) begin
         state <= I2CT_ADDR;
         cnt <= 4'h0;
         o_sda_oe <= 1'b0;
      end else if (stop_c) begin
         state <= I2CT_IDLE;
         o_sda_oe <= 1'b0;
      end else begin
         case (state)
            I2CT_ADDR, I2CT_RX: begin
               // Shift in most significant bit first
               if (scl_rise) begin
                  shreg <= {shreg[6:0], sda2};
                  cnt <= cnt + 4'h1;
               end
               if (byte_done) begin
                  cnt <= 4'h0;
                  if (state == I2CT_ADDR) begin
                     byte_idx <= 2'h0;
                     if (addr_hit) begin
                        o_sda_oe <= 1'b1;
                        rw <= shreg[0];
                        state <= I2CT_ADDR_ACK;
                        // First fetch starts in the ack bit
                        if (shreg[0]) begin
                           req_tog <= ~req_tog;
                           req_kind <= is_status ? I2CT_K_STATUS : I2CT_K_READ;
                           req_addr <= link_addr;
                           if (!is_status)
                              link_addr <= link_addr + 16'h0001;
                        end
                     end else begin
                        state <= I2CT_IDLE;
                     end
                  end else begin
                     o_sda_oe <= 1'b1;
                     state <= I2CT_RX_ACK;
                     if (byte_idx != `I2CT_IDX_DATA)
                        byte_idx <= byte_idx + 2'h1;
                     case (byte_idx)
                        2'h0: begin
                           // Command byte; write-enable goes out alone
                           cmd <= shreg;
                           if (shreg == `I2CT_CMD_WREN) begin
                              req_tog <= ~req_tog;
                              req_kind <= I2CT_K_WREN;
                           end
                        end
                        // Two address bytes follow the command
                        2'h1: link_addr[15:8] <= shreg;
                        2'h2: link_addr[7:0] <= shreg;
                        default: begin
                           // Store the byte, then bump the address
                           if (cmd == `I2CT_CMD_WRITE) begin
                              req_tog <= ~req_tog;
                              req_kind <= I2CT_K_WRITE;
                              req_addr <= link_addr;
                              req_data <= shreg;
                              link_addr <= link_addr + 16'h0001;
                           end
                        end
                     endcase
                  end
               end
            end
            I2CT_ADDR_ACK, I2CT_TX_ACK: begin
               if (scl_rise)
                  mack <= ~sda2;
               if (scl_fall) begin
                  cnt <= 4'h1;
                  if (state == I2CT_ADDR_ACK && !rw) begin
                     o_sda_oe <= 1'b0;
                     state <= I2CT_RX;
                     cnt <= 4'h0;
                  end else if (state == I2CT_ADDR_ACK || mack) begin
                     // Fetched byte goes out MSB first
                     o_sda_oe <= ~fetched[7];
                     txreg <= {fetched[6:0], 1'b0};
                     state <= I2CT_TX;
                  end else begin
                     // Master NACK: wait for STOP with the line released
                     o_sda_oe <= 1'b0;
                     state <= I2CT_IDLE;
                  end
               end
            end
            I2CT_TX: begin
               if (scl_fall) begin
                  if (cnt == `I2CT_BITS) begin
                     // Prefetch next location during the ack bit
                     o_sda_oe <= 1'b0;
                     state <= I2CT_TX_ACK;
                     req_tog <= ~req_tog;
                     req_kind <= is_status ? I2CT_K_STATUS : I2CT_K_READ;
                     req_addr <= link_addr;
                     if (!is_status)
                        link_addr <= link_addr + 16'h0001;
                  end else begin
                     o_sda_oe <= ~txreg[7];
                     txreg <= {txreg[6:0], 1'b0};
                     cnt <= cnt + 4'h1;
                  end
               end
            end
            I2CT_RX_ACK: begin
               if (scl_fall) begin
                  o_sda_oe <= 1'b0;
                  state <= I2CT_RX;
               end
            end
            default: begin
               o_sda_oe <= 1'b0;
            end
         endcase
      end
   end
   // Core domain: request toggle crossing and command stream
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         {rq1, rq2, rq3} <= 3'h0;
         o_addr <= 16'h0000;
         o_wdata <= 8'h00;
         o_space <= 1'b0;
         o_wr_strobe <= 1'b0;
         o_rd_strobe <= 1'b0;
         o_write_enable <= 1'b0;
         rd_pend <= 1'b0;
         st_pend <= 1'b0;
      end else begin
         {rq1, rq2, rq3} <= {req_tog, rq1, rq2};
         // Space select travels with every access
         if (req_edge) begin
            o_addr <= req_addr;
            o_wdata <= req_data;
            o_space <= i_memory_space_select;
         end
         o_wr_strobe <= req_edge & (req_kind == I2CT_K_WRITE);
         o_rd_strobe <= req_edge & (req_kind == I2CT_K_READ);
         o_write_enable <= req_edge & (req_kind == I2CT_K_WREN);
         // Target answers one cycle after the strobe, so wait for it
         rd_pend <= o_rd_strobe;
         st_pend <= req_edge & (req_kind == I2CT_K_STATUS);
      end
   end
   // Status byte carries the busy flag in bit 0
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         rsp_data <= 8'h00;
         rsp_tog <= 1'b0;
      end else if (rd_pend | st_pend) begin
         rsp_data <= rd_pend ? i_rdata : {7'h00, i_ee_busy};
         rsp_tog <= ~rsp_tog;
      end
   end
   // Strap capture after release, script overrides
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         pin1 <= 2'h0;
         pin2 <= 2'h0;
         strap_cnt <= 2'h0;
         o_slave_address <= `I2CT_ADDR_RESET;
         sa_tog <= 1'b0;
      end else begin
         pin1 <= i_addr_pins;
         pin2 <= pin1;
         if (strap_cnt != `I2CT_STRAP_DONE)
            strap_cnt <= strap_cnt + 2'h1;
         if (i_sa_write) begin
            o_slave_address <= i_sa_data;
            sa_tog <= ~sa_tog;
         end else if (strap_cnt == `I2CT_STRAP_WAIT) begin
            o_slave_address <= {`I2CT_ADDR_UPPER, pin2};
            sa_tog <= ~sa_tog;
         end
      end
   end
   // Checks in the link domain
   ack_on_match_a: assert property (@(posedge i_link_clk) disable iff (i_reset)
      (state == I2CT_ADDR && byte_done && addr_hit && !start_c && !stop_c)
      |=> o_sda_oe && state == I2CT_ADDR_ACK)
      else $error("own address not acknowledged");
   ignore_other_a: assert property (@(posedge i_link_clk) disable iff (i_reset)
      (state == I2CT_ADDR && byte_done && !addr_hit && !start_c && !stop_c)
      |=> !o_sda_oe && state == I2CT_IDLE)
      else $error("foreign address answered");
   restart_addr_a: assert property (@(posedge i_link_clk) disable iff (i_reset)
      start_c |=> state == I2CT_ADDR && cnt == 4'h0 && !o_sda_oe)
      else $error("start did not restart address phase");
   stop_release_a: assert property (@(posedge i_link_clk) disable iff (i_reset)
      (stop_c && !start_c) |=> state == I2CT_IDLE && !o_sda_oe)
      else $error("stop did not release the bus");
   read_bump_a: assert property (@(posedge i_link_clk) disable iff (i_reset)
      (state == I2CT_TX && scl_fall && cnt == `I2CT_BITS && !is_status
       && !start_c && !stop_c)
      |=> link_addr == $past(link_addr) + 16'h0001 && $changed(req_tog))
      else $error("read address not advanced with fetch");
   msb_first_a: assert property (@(posedge i_link_clk) disable iff (i_reset)
      (state == I2CT_TX && scl_fall && cnt != `I2CT_BITS && !start_c && !stop_c)
      |=> o_sda_oe == !$past(txreg[7]))
      else $error("transmit bit order wrong");
   write_req_a: assert property (@(posedge i_link_clk) disable iff (i_reset)
      (state == I2CT_RX && byte_done && byte_idx == `I2CT_IDX_DATA
       && cmd == `I2CT_CMD_WRITE && !start_c && !stop_c)
      |=> $changed(req_tog) && req_kind == I2CT_K_WRITE && req_data == $past(shreg))
      else $error("data byte not forwarded");
   // Checks in the core domain
   rd_answer_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_rd_strobe |=> ##1 ($changed(rsp_tog) && rsp_data == $past(i_rdata)))
      else $error("read data not returned");
   status_bit_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      st_pend |=> rsp_data == {7'h00, $past(i_ee_busy)})
      else $error("status byte wrong");
   strap_upper_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (strap_cnt == `I2CT_STRAP_WAIT && !i_sa_write)
      |=> o_slave_address[6:2] == `I2CT_ADDR_UPPER)
      else $error("default address upper bits wrong");
   cov_read_c: cover property (@(posedge i_link_clk) disable iff (i_reset)
      state == I2CT_TX_ACK && scl_fall && !mack);
   cov_write_c: cover property (@(posedge i_mclk) disable iff (i_reset) o_wr_strobe);
   cov_status_c: cover property (@(posedge i_mclk) disable iff (i_reset) st_pend);
endmodule
